// [bpo_pkg.sv]
// Shared constants and types for the bridge PWM output steering block
package bpo_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTL = 8'h00;
    localparam logic [7:0] OFS_DUTY = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_TIMER = 8'h0C;
    localparam logic [7:0] OFS_DEADBAND = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h14;
    localparam logic [7:0] OFS_DIR = 8'h18;
    localparam logic [7:0] OFS_PORT = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_MODE_LSB = 6;
    localparam int CTL_DUTYLO_LSB = 4;
    localparam int TMR_RUN_BIT = 2;
    localparam int STAT_SHADOW_LSB = 16;
    localparam logic [1:0] POL_PWM_MODE = 2'h3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [2:0] RST_TIMER = 3'h0;
    localparam logic [6:0] RST_DEADBAND = 7'h00;
    localparam logic [3:0] RST_DIR = 4'hF;
    localparam logic [3:0] RST_PORT = 4'h0;
    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam logic [1:0] INSTR_DIV_LIM = 2'h3;
    localparam logic [7:0] NEAR_END_COUNTS = 8'h04;
    localparam logic [3:0] PS1_LIM = 4'h0;
    localparam logic [3:0] PS4_LIM = 4'h3;
    localparam logic [3:0] PS16_LIM = 4'hF;
    // ------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_FULL_FWD = 2'b01,
        MODE_HALF = 2'b10,
        MODE_FULL_REV = 2'b11
    } bpo_mode_t;
    typedef enum logic [1:0] {
        DIR_RUN = 2'b00,
        DIR_PENDING = 2'b01,
        DIR_BLANK = 2'b10
    } bpo_dir_state_t;
endpackage : bpo_pkg

// [bpo_tb_if.sv]
// Signals between the steering logic and the time base
`timescale 1ns/1ps
interface bpo_tb_if;
    logic run;
    logic [1:0] prescale;
    logic [7:0] period;
    logic [9:0] duty;
    logic [9:0] base;
    logic [9:0] shadow;
    logic raw;
    logic period_start;
    logic near_end;
    modport tb (input run, input prescale, input period, input duty,
                output base, output shadow, output raw, output period_start,
                output near_end);
    modport ctl (output run, output prescale, output period, output duty,
                 input base, input shadow, input raw, input period_start,
                 input near_end);
endinterface : bpo_tb_if

// [bpo_timebase.sv]
// Ten-bit PWM time base with prescaler and duty shadow
`timescale 1ns/1ps
module bpo_timebase (
    input wire logic clk,
    input wire logic nrst,
    bpo_tb_if.tb tb
);
    logic [3:0] pre_cnt_r;
    logic [3:0] pre_lim;
    logic tick;
    logic wrap;
    logic [9:0] base_inc;
    logic [9:0] base_nxt;
    logic [7:0] near_timer;

    always_comb begin
        case (tb.prescale)
            2'b00: pre_lim = bpo_pkg::PS1_LIM;
            2'b01: pre_lim = bpo_pkg::PS4_LIM;
            default: pre_lim = bpo_pkg::PS16_LIM;
        endcase
    end

    assign tick = tb.run && (pre_cnt_r == pre_lim);
    assign wrap = tick && (tb.base == {tb.period, 2'b11});
    assign base_inc = tb.base + 10'h001;
    // Next base value, so a four-count period still blanks from its first count
    assign base_nxt = wrap ? 10'h000 : base_inc;
    assign near_timer = tb.period + 8'h01 - bpo_pkg::NEAR_END_COUNTS;

    always_ff @(posedge clk) begin
        if (!nrst || !tb.run || tick) begin
            pre_cnt_r <= 4'h0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tb.base <= 10'h000;
        end else if (wrap) begin
            tb.base <= 10'h000; // RL23
        end else if (tick) begin
            tb.base <= base_inc;
        end
    end

    // Duty is double buffered so a mid-period write never glitches the pulse
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tb.shadow <= 10'h000;
            tb.raw <= 1'b0;
        end else if (wrap) begin
            tb.shadow <= tb.duty; // RL23
            tb.raw <= (tb.duty != 10'h000); // RL23
        end else if (tick && (base_inc == tb.shadow)) begin
            tb.raw <= 1'b0; // RL24
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tb.period_start <= 1'b0;
            tb.near_end <= 1'b0;
        end else begin
            tb.period_start <= wrap;
            tb.near_end <= tick && (base_nxt == {near_timer, 2'b00}); // RL17
        end
    end

    a_duty_latch: assert property (@(posedge clk) disable iff (!nrst)
        wrap |=> tb.shadow == $past(tb.duty)) else $error("duty not latched at wrap"); // RL23
    a_pulse_end: assert property (@(posedge clk) disable iff (!nrst)
        (tick && !wrap && base_inc == tb.shadow) |=> !tb.raw)
        else $error("pulse not ended at duty match"); // RL24
endmodule : bpo_timebase

// [bpo_deadband.sv]
// Rising-edge delay for one half-bridge output
`timescale 1ns/1ps
module bpo_deadband #(
    parameter int CW = 7
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_sig,
    input wire logic tick,
    input wire logic [CW-1:0] count,
    output logic out_sig
);
    logic [CW-1:0] cnt_r;

    // A pulse shorter than the delay never reaches the output
    always_ff @(posedge clk) begin
        if (!nrst || !in_sig) begin
            cnt_r <= '0;
            out_sig <= 1'b0; // RL13
        end else if (!out_sig) begin
            if (cnt_r == count) begin
                out_sig <= 1'b1; // RL12
            end else if (tick) begin
                cnt_r <= cnt_r + 1'b1; // RL12
            end
        end
    end

    a_db_rise: assert property (@(posedge clk) disable iff (!nrst)
        $rose(out_sig) |-> $past(in_sig) && $past(cnt_r) == $past(count))
        else $error("output rose before delay elapsed"); // RL12
    a_db_fall: assert property (@(posedge clk) disable iff (!nrst)
        !in_sig |=> !out_sig) else $error("output active without input"); // RL13
endmodule : bpo_deadband

// [bpo_steer.sv]
// Bridge PWM output steering: APB registers, mode steering, dead band, direction change
//
// Function
// [RL1] All PWM timing counts CLK edges only; clock changes scale the frequency.
// [RL2] Reset restores all control registers and turns every pin into an input.
// [RL3] Software keeps pins input, loads period, mode, duty, then starts timer.
// [RL4] Software enables pin drivers only after the period match flag sets.
// [RL5] Mode field: 00 single, 10 half, 01 full forward, 11 full reverse.
// [RL6] Up to four outputs, ten-bit duty; single uses first, half first two.
// [RL7] Full-bridge modes drive all four outputs.
// [RL8] After enabling, outputs stay inactive until the next period starts.
// [RL9] Clearing the control register returns all pins to port function.
// [RL10] Pins unused by the mode keep their ordinary port function.
// [RL11] Half-bridge: modulated signal on first output, complement on second.
// [RL12] Half-bridge delays each turn-on by seven-bit count of 4-clock cycles.
// [RL13] Delay longer than the active interval keeps that output inactive.
// [RL14] Forward: first active, fourth modulated, second and third inactive.
// [RL15] Reverse: third active, second modulated, first and fourth inactive.
// [RL16] Direction bit may change anytime; new direction applies next cycle.
// [RL17] Four counts before period end: blank modulated, swap others, resume.
// [RL18] No dead band in full-bridge modes.
// [RL19] Two polarity bits set active level of pairs first/third, second/fourth.
// [RL20] Software sets polarity before driving pins and leaves it alone.
// [RL21] Software lets one full cycle pass in mode before driving pins.
// [RL22] Period match flag sets when the second period begins.
// [RL23] At period end timer clears, output sets unless zero, duty latches.
// [RL24] Active pulse ends when time base equals latched duty.
// [RL25] Duty: upper eight bits in duty register, lower two in control.
// [RL26] Inactive outputs show the inverse of their pair's active level.
`timescale 1ns/1ps
module bpo_steer #(
    parameter int DB_W = 7
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [3:0] PIN_OUT,
    output logic [3:0] PIN_OE
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctl_r;
    logic [7:0] duty_r;
    logic [7:0] period_r;
    logic [2:0] timer_ctl_r;
    logic [DB_W-1:0] deadband_r;
    logic flag_r;
    logic [3:0] dir_latch_r;
    logic [3:0] port_r;
    logic [1:0] icnt_r;
    logic started_r;
    logic dir_cur_r;
    bpo_pkg::bpo_dir_state_t dstate_r;
    bpo_pkg::bpo_dir_state_t dstate_nxt;
    logic [3:0] act;
    logic [3:0] own;
    logic [3:0] low;
    logic [3:0] pin_out_nxt;
    logic [31:0] rdata_nxt;
    logic addr_ok;
    logic setup;
    logic wr_en;
    logic itick;
    logic en;
    logic full;
    logic pwm;
    logic blank;
    logic db_a;
    logic db_b;
    bpo_pkg::bpo_mode_t mode;

    bpo_tb_if tbi ();

    bpo_timebase u_timebase (
        .clk(CLK),
        .nrst(NRST),
        .tb(tbi.tb)
    );

    assign tbi.run = timer_ctl_r[bpo_pkg::TMR_RUN_BIT];
    assign tbi.prescale = timer_ctl_r[1:0];
    assign tbi.period = period_r;
    assign tbi.duty = {duty_r, ctl_r[bpo_pkg::CTL_DUTYLO_LSB +: 2]}; // RL25

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

    always_comb begin
        addr_ok = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (PADDR)
            bpo_pkg::OFS_CTL: rdata_nxt[7:0] = ctl_r;
            bpo_pkg::OFS_DUTY: rdata_nxt[7:0] = duty_r;
            bpo_pkg::OFS_PERIOD: rdata_nxt[7:0] = period_r;
            bpo_pkg::OFS_TIMER: rdata_nxt[2:0] = timer_ctl_r;
            bpo_pkg::OFS_DEADBAND: rdata_nxt[DB_W-1:0] = deadband_r;
            bpo_pkg::OFS_FLAG: rdata_nxt[0] = flag_r;
            bpo_pkg::OFS_DIR: rdata_nxt[3:0] = dir_latch_r;
            bpo_pkg::OFS_PORT: rdata_nxt[3:0] = port_r;
            bpo_pkg::OFS_STATUS: begin
                rdata_nxt[9:0] = tbi.base;
                rdata_nxt[bpo_pkg::STAT_SHADOW_LSB +: 10] = tbi.shadow;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait-free access: ready rises at the first access edge
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else if (setup) begin
            PREADY <= 1'b1;
            PSLVERR <= !addr_ok;
            PRDATA <= PWRITE ? 32'h0000_0000 : rdata_nxt;
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ctl_r <= bpo_pkg::RST_CTL; // RL2
            duty_r <= bpo_pkg::RST_DUTY;
            period_r <= bpo_pkg::RST_PERIOD;
            timer_ctl_r <= bpo_pkg::RST_TIMER;
            deadband_r <= bpo_pkg::RST_DEADBAND;
            dir_latch_r <= bpo_pkg::RST_DIR; // RL2
            port_r <= bpo_pkg::RST_PORT;
        end else if (wr_en) begin
            case (PADDR)
                bpo_pkg::OFS_CTL: ctl_r <= PWDATA[7:0];
                bpo_pkg::OFS_DUTY: duty_r <= PWDATA[7:0];
                bpo_pkg::OFS_PERIOD: period_r <= PWDATA[7:0];
                bpo_pkg::OFS_TIMER: timer_ctl_r <= PWDATA[2:0];
                bpo_pkg::OFS_DEADBAND: deadband_r <= PWDATA[DB_W-1:0];
                bpo_pkg::OFS_DIR: dir_latch_r <= PWDATA[3:0];
                bpo_pkg::OFS_PORT: port_r <= PWDATA[3:0];
                default: ;
            endcase
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            flag_r <= 1'b0;
        end else if (tbi.period_start) begin
            flag_r <= 1'b1; // RL22
        end else if (wr_en && PADDR == bpo_pkg::OFS_FLAG && PWDATA[0]) begin
            flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Instruction-cycle divider for the dead band
    // ------------------------------------------------------------
    assign itick = (icnt_r == bpo_pkg::INSTR_DIV_LIM);

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            icnt_r <= 2'h0;
        end else begin
            icnt_r <= icnt_r + 2'h1; // RL1
        end
    end

    // ------------------------------------------------------------
    // Enable and start synchronisation
    // ------------------------------------------------------------
    assign en = (ctl_r[3:2] == bpo_pkg::POL_PWM_MODE);
    assign mode = bpo_pkg::bpo_mode_t'(ctl_r[bpo_pkg::CTL_MODE_LSB +: 2]); // RL5
    assign full = mode[0];

    always_ff @(posedge CLK) begin
        if (!NRST || !en) begin
            started_r <= 1'b0;
        end else if (tbi.period_start) begin
            started_r <= 1'b1; // RL8
        end
    end

    // ------------------------------------------------------------
    // Direction change sequencing
    // ------------------------------------------------------------
    always_comb begin
        dstate_nxt = dstate_r;
        case (dstate_r)
            bpo_pkg::DIR_RUN: begin
                if (full && mode[1] != dir_cur_r) begin
                    dstate_nxt = bpo_pkg::DIR_PENDING; // RL16
                end
            end
            bpo_pkg::DIR_PENDING: begin
                if (!full || mode[1] == dir_cur_r) begin
                    dstate_nxt = bpo_pkg::DIR_RUN;
                end else if (tbi.near_end) begin
                    dstate_nxt = bpo_pkg::DIR_BLANK; // RL17
                end
            end
            bpo_pkg::DIR_BLANK: begin
                if (tbi.period_start || !full) begin
                    dstate_nxt = bpo_pkg::DIR_RUN; // RL17
                end
            end
            default: dstate_nxt = bpo_pkg::DIR_RUN;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            dstate_r <= bpo_pkg::DIR_RUN;
            dir_cur_r <= 1'b0;
        end else begin
            dstate_r <= dstate_nxt;
            if (!full || !started_r) begin
                dir_cur_r <= mode[1];
            end else if (dstate_r == bpo_pkg::DIR_PENDING && dstate_nxt == bpo_pkg::DIR_BLANK) begin
                dir_cur_r <= mode[1]; // RL17
            end
        end
    end

    // Modulation is back on the first clock of the new period
    assign blank = (dstate_r == bpo_pkg::DIR_BLANK) && !tbi.period_start; // RL17

    // ------------------------------------------------------------
    // Dead band for the half-bridge pair
    // ------------------------------------------------------------
    assign pwm = tbi.raw && started_r; // RL8

    bpo_deadband #(.CW(DB_W)) u_db_a (
        .clk(CLK),
        .nrst(NRST),
        .in_sig(pwm),
        .tick(itick),
        .count(deadband_r),
        .out_sig(db_a)
    );

    bpo_deadband #(.CW(DB_W)) u_db_b (
        .clk(CLK),
        .nrst(NRST),
        .in_sig(started_r && !tbi.raw),
        .tick(itick),
        .count(deadband_r),
        .out_sig(db_b)
    );

    // ------------------------------------------------------------
    // Output steering
    // ------------------------------------------------------------
    always_comb begin
        act = 4'h0;
        own = 4'h0;
        if (full) begin
            own = 4'hF; // RL7
            // Full bridge takes the raw pulse, never the delayed one
            if (!dir_cur_r) begin
                act[0] = started_r; // RL14
                act[3] = pwm && !blank; // RL14 RL18
            end else begin
                act[2] = started_r; // RL15
                act[1] = pwm && !blank; // RL15 RL18
            end
        end else if (mode == bpo_pkg::MODE_HALF) begin
            own = 4'h3; // RL6
            act[0] = db_a; // RL11
            act[1] = db_b; // RL11
        end else begin
            own = 4'h1; // RL6
            act[0] = pwm;
        end
        if (!en) begin
            own = 4'h0; // RL9
        end
    end

    assign low = {ctl_r[0], ctl_r[1], ctl_r[0], ctl_r[1]}; // RL19

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_out_nxt[i] = own[i] ? (act[i] ^ low[i]) : port_r[i]; // RL10 RL26
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PIN_OUT <= 4'h0;
            PIN_OE <= 4'h0; // RL2
        end else begin
            PIN_OUT <= pin_out_nxt;
            PIN_OE <= ~dir_latch_r;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reset_inputs: assert property (@(posedge CLK)
        !NRST |=> PIN_OE == 4'h0) else $error("pins driven after reset"); // RL2
    a_hold_start: assert property (@(posedge CLK) disable iff (!NRST)
        (en && !started_r) |-> act == 4'h0) else $error("output before period start"); // RL8
    a_release_pins: assert property (@(posedge CLK) disable iff (!NRST)
        ctl_r == 8'h00 |=> PIN_OUT == $past(port_r)) else $error("pins not released"); // RL9
    a_half_unused: assert property (@(posedge CLK) disable iff (!NRST)
        (en && mode == bpo_pkg::MODE_HALF) |=> PIN_OUT[3:2] == $past(port_r[3:2]))
        else $error("unused pins disturbed"); // RL10
    a_forward_map: assert property (@(posedge CLK) disable iff (!NRST)
        (en && started_r && full && !dir_cur_r) |-> act[0] && !act[1] && !act[2])
        else $error("forward mapping wrong"); // RL14
    a_reverse_map: assert property (@(posedge CLK) disable iff (!NRST)
        (en && started_r && full && dir_cur_r) |-> act[2] && !act[0] && !act[3])
        else $error("reverse mapping wrong"); // RL15
    a_blank_cause: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(blank) |-> $past(tbi.near_end) && dir_cur_r == mode[1])
        else $error("blanking without near-end"); // RL17
    a_blank_mod: assert property (@(posedge CLK) disable iff (!NRST)
        blank |-> !act[1] && !act[3]) else $error("modulated output active in blank"); // RL17
    a_polarity_pin: assert property (@(posedge CLK) disable iff (!NRST)
        ##1 $past(own[0]) |-> PIN_OUT[0] == ($past(act[0]) ^ $past(ctl_r[1])))
        else $error("first output polarity wrong"); // RL19 RL26
    a_flag_sets: assert property (@(posedge CLK) disable iff (!NRST)
        tbi.period_start |=> flag_r) else $error("match flag not set"); // RL22
    a_apb_ready: assert property (@(posedge CLK) disable iff (!NRST)
        setup |=> PREADY ##1 !PREADY) else $error("ready not one access cycle");

    c_half_run: cover property (@(posedge CLK) disable iff (!NRST)
        en && mode == bpo_pkg::MODE_HALF && $rose(db_b));
    c_dir_change: cover property (@(posedge CLK) disable iff (!NRST)
        $rose(blank) ##[1:300] $fell(blank));
    c_fwd_pulse: cover property (@(posedge CLK) disable iff (!NRST)
        en && full && !dir_cur_r && $rose(act[3]));
    c_bad_addr: cover property (@(posedge CLK) disable iff (!NRST) PSLVERR);
endmodule : bpo_steer

// [bpo_bridge_drv.sv]
// Model of the bridge switch drivers sensing the four steering pins
`timescale 1ns/1ps
module bpo_bridge_drv (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    output logic [3:0] gate
);
    // ------------------------------------------------------------
    // Pin sensing
    // ------------------------------------------------------------
    // Released pins fall to the board pull-downs, so switches stay off
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gate[i] = pin_oe[i] ? pin_out[i] : 1'b0;
        end
    end
endmodule : bpo_bridge_drv

// [bridge_pwm_output_steering_bench.sv]
// Self-checking bench for the bridge PWM output steering block
`timescale 1ns/1ps
module bridge_pwm_output_steering_bench;
    typedef struct packed {logic [7:0] ctl; logic [7:0] duty; logic [3:0] pins;} bpo_row_t;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [3:0] PIN_OUT;
    logic [3:0] PIN_OE;
    logic [3:0] lvl;
    logic [31:0] rdat;
    logic slverr;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int c0, c1, cp;
    // Port latch shows 1010 on pins the mode leaves alone
    bpo_row_t rows [8] = '{'{8'h0C, 8'hFF, 4'hB}, '{8'h8C, 8'h00, 4'hA},
        '{8'h8F, 8'h00, 4'h9}, '{8'h4C, 8'hFF, 4'h9}, '{8'hCC, 8'hFF, 4'h6},
        '{8'h4F, 8'h00, 4'hE}, '{8'hCE, 8'h00, 4'h1}, '{8'h40, 8'hFF, 4'hA}};

    bpo_steer #(.DB_W(7)) uut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
    bpo_bridge_drv drv (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .gate(lvl));

    initial begin
        forever #25 CLK = ~CLK;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rdat = PRDATA;
        slverr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic sample(input int n);
        c0 = 0;
        c1 = 0;
        cp = 0;
        repeat (n) begin
            @(posedge CLK);
            c0 += int'(lvl[0]);
            c1 += int'(lvl[1]);
            cp += int'(lvl == 4'h4);
        end
    endtask : sample

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Whole run needs about 3000 cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge CLK);
        chk({28'h0, PIN_OE}, 32'h0);
        NRST <= 1'b1;
        apb(1'b0, bpo_pkg::OFS_CTL, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, bpo_pkg::OFS_PERIOD, 32'h0);
        chk(rdat, 32'hFF);
        apb(1'b0, bpo_pkg::OFS_DIR, 32'h0);
        chk(rdat, 32'hF);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, slverr}, 32'h1);
        $display("test reset values done");
        apb(1'b1, bpo_pkg::OFS_PERIOD, 32'h3);
        apb(1'b1, bpo_pkg::OFS_CTL, 32'hC);
        apb(1'b1, bpo_pkg::OFS_PORT, 32'hA);
        apb(1'b1, bpo_pkg::OFS_FLAG, 32'h1);
        apb(1'b0, bpo_pkg::OFS_FLAG, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, bpo_pkg::OFS_TIMER, 32'h4);
        repeat (40) @(posedge CLK);
        apb(1'b0, bpo_pkg::OFS_FLAG, 32'h0);
        chk(rdat, 32'h1);
        apb(1'b1, bpo_pkg::OFS_DIR, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, bpo_pkg::OFS_DUTY, {24'h0, rows[i].duty});
            apb(1'b1, bpo_pkg::OFS_CTL, {24'h0, rows[i].ctl});
            repeat (80) @(posedge CLK);
            chk({28'h0, lvl}, {28'h0, rows[i].pins});
        end
        $display("test mode table done");
        apb(1'b1, bpo_pkg::OFS_DUTY, 32'h1);
        apb(1'b1, bpo_pkg::OFS_CTL, 32'h2C);
        // Prescale 1, 4 and 16: two periods each, pulse of six base counts
        for (int p = 0; p < 3; p++) begin
            apb(1'b1, bpo_pkg::OFS_TIMER, 32'(4 + p));
            repeat (150 << p) @(posedge CLK);
            sample(32 << (2 * p));
            chk(c0, 12 << (2 * p));
        end
        apb(1'b1, bpo_pkg::OFS_TIMER, 32'h4);
        apb(1'b1, bpo_pkg::OFS_DEADBAND, 32'h7F);
        apb(1'b1, bpo_pkg::OFS_CTL, 32'hAC);
        repeat (100) @(posedge CLK);
        sample(64);
        chk(c0 + c1, 0);
        $display("test pulse width done");
        apb(1'b1, bpo_pkg::OFS_PERIOD, 32'hF);
        apb(1'b1, bpo_pkg::OFS_DUTY, 32'hFF);
        apb(1'b1, bpo_pkg::OFS_CTL, 32'h4C);
        repeat (200) @(posedge CLK);
        chk({28'h0, lvl}, 32'h9);
        apb(1'b1, bpo_pkg::OFS_CTL, 32'hCC);
        sample(100);
        chk(32'(cp > 14 && cp < 18), 32'h1);
        chk({28'h0, lvl}, 32'h6);
        $display("test direction change done");
        NRST <= 1'b0;
        repeat (2) @(posedge CLK);
        chk({28'h0, PIN_OE}, 32'h0);
        NRST <= 1'b1;
        apb(1'b0, bpo_pkg::OFS_CTL, 32'h0);
        chk(rdat, 32'h0);
        $display("test second reset done");
        print_verdict();
    end
endmodule : bridge_pwm_output_steering_bench
